// *** dhtc_pkg.sv ***
// Purpose: constants and types of the dma grant and terminal-count unit
// Assumes: one 125 MHz system clock, registers on axi4-lite, 12-bit byte address
// Notes: channel 4 is the cascade channel and never requests
package dhtc_pkg;
   localparam int NUM_CH = 8;
   localparam logic [2:0] CASCADE_CH = 3'h4;
   // register byte offsets
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_MASK = 12'h004;
   localparam logic [11:0] OFS_STATUS = 12'h008;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h00c;
   localparam logic [11:0] OFS_AUTOINIT = 12'h010;
   // per-channel block: address[11:7] selects it, [6:4] the channel, [3:2] the field
   localparam logic [4:0] OFS_CH_BLOCK = 5'h01;
   localparam logic [1:0] FLD_BASE_ADDR = 2'h0;
   localparam logic [1:0] FLD_BASE_COUNT = 2'h1;
   localparam logic [1:0] FLD_CUR_ADDR = 2'h2;
   localparam logic [1:0] FLD_CUR_COUNT = 2'h3;
   // control fields
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_NONCACHE_BIT = 1;
   localparam int CTRL_MEM2MEM_BIT = 2;
   localparam int CTRL_POL_LSB = 8;
   // status fields
   localparam int STAT_REQ_LSB = 8;
   localparam int STAT_ACH_LSB = 16;
   localparam int STAT_BUSY_BIT = 19;
   // values after reset
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;
   localparam logic [7:0] RST_MASK = 8'hff;
   localparam logic [7:0] RST_IRQ_MASK = 8'h00;
   localparam logic [7:0] RST_AUTOINIT = 8'h00;
   localparam logic [7:0] RST_GRANT = 8'hff;
   // a transfer spans two dma clock periods; the pulse sits on the last one
   localparam logic XFER_LAST_PHASE = 1'b1;
   // bus responses
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   typedef enum logic [0:0] {
      DHTC_IDLE = 1'b0,
      DHTC_XFER = 1'b1
   } dhtc_state_t;
endpackage

// *** dhtc_top.sv ***
// Purpose: dma request, grant and terminal-count handshake with an axi4-lite register file
// Assumes: dma clock is every rising edge of the synchronised 14.318 MHz reference
// Notes: single transfer mode; requests are rearbitrated after each transfer
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dhtc_top (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_arst_n,
   // axi4-lite write
   input wire logic i_s_axi_awvalid,
   input wire logic [11:0] i_s_axi_awaddr,
   output logic o_s_axi_awready,
   input wire logic i_s_axi_wvalid,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   output logic o_s_axi_wready,
   output logic o_s_axi_bvalid,
   output logic [1:0] o_s_axi_bresp,
   input wire logic i_s_axi_bready,
   // axi4-lite read
   input wire logic i_s_axi_arvalid,
   input wire logic [11:0] i_s_axi_araddr,
   output logic o_s_axi_arready,
   output logic o_s_axi_rvalid,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   input wire logic i_s_axi_rready,
   // shared pins and reference
   input wire logic i_reference_clock_in,
   input wire logic [2:0] i_tag_data_low_bits,
   input wire logic [3:0] i_cache_byte_select_n,
   // dma handshake
   output logic [3:0] o_dma_grant_low_channels,
   output logic [2:0] o_dma_grant_high_channels,
   output logic o_count_done_pulse,
   output logic o_io_channel_degate,
   output logic o_irq
);
   // pin synchroniser: bit 7 is the reference, 6:4 tag pins, 3:0 byte selects
   logic [7:0] sync1_q, sync2_q, sync3_q, filt_q, filt_d;
   logic ref_prev_q;
   logic tick;

   always_comb
   begin
      // a bit moves only once the second and third stages agree
      filt_d = (sync2_q & ~(sync2_q ^ sync3_q)) | (filt_q & (sync2_q ^ sync3_q));
   end

   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         sync1_q <= 8'h00;
         sync2_q <= 8'h00;
         sync3_q <= 8'h00;
         filt_q <= 8'h00;
         ref_prev_q <= 1'b0;
      end
      else
      begin
         sync1_q <= {i_reference_clock_in, i_tag_data_low_bits, i_cache_byte_select_n};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         filt_q <= filt_d;
         ref_prev_q <= filt_q[7];
      end
   end

   assign tick = filt_q[7] & ~ref_prev_q;

   // main state
   dhtc_pkg::dhtc_state_t st_q, st_d;
   logic ph_q, ph_d, m2m_q, m2m_d, tc_q, tc_d, irq_q, irq_d, degate_q, degate_d;
   logic [2:0] ach_q, ach_d;
   logic [31:0] ctrl_q, ctrl_d;
   logic [7:0] mask_q, mask_d, stat_q, stat_d, imask_q, imask_d, auto_q, auto_d;
   logic [7:0] grant_q, grant_d;
   logic [15:0] baddr_q [dhtc_pkg::NUM_CH], baddr_d [dhtc_pkg::NUM_CH];
   logic [15:0] bcnt_q [dhtc_pkg::NUM_CH], bcnt_d [dhtc_pkg::NUM_CH];
   logic [15:0] caddr_q [dhtc_pkg::NUM_CH], caddr_d [dhtc_pkg::NUM_CH];
   logic [15:0] ccnt_q [dhtc_pkg::NUM_CH], ccnt_d [dhtc_pkg::NUM_CH];
   // bus state
   logic awready_q, awready_d, wready_q, wready_d, have_aw_q, have_aw_d, have_w_q, have_w_d;
   logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [11:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   // combinational helpers
   logic [7:0] req, req_ok, act;
   logic [2:0] pick;
   logic found, m2m_go, do_wr, wr_map, rd_map, final_xfer;
   logic [31:0] rd_val;
   logic [2:0] wch, rch;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   always_comb
   begin
      st_d = st_q;
      ph_d = ph_q;
      m2m_d = m2m_q;
      tc_d = tc_q;
      ach_d = ach_q;
      ctrl_d = ctrl_q;
      mask_d = mask_q;
      stat_d = stat_q;
      imask_d = imask_q;
      auto_d = auto_q;
      baddr_d = baddr_q;
      bcnt_d = bcnt_q;
      caddr_d = caddr_q;
      ccnt_d = ccnt_q;
      awready_d = awready_q;
      wready_d = wready_q;
      have_aw_d = have_aw_q;
      have_w_d = have_w_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      // requests exist only while the shared pins are not in cache use
      req = ctrl_q[dhtc_pkg::CTRL_NONCACHE_BIT] ?
            {filt_q[6:4], 1'b0, filt_q[3:0]} : 8'h00;
      req_ok = req & ~mask_q;
      pick = 3'h0;
      for (int i = dhtc_pkg::NUM_CH - 1; i >= 0; i--)
      begin
         if (req_ok[i])
         begin
            pick = 3'(i);
         end
      end
      found = |req_ok;
      m2m_go = ctrl_q[dhtc_pkg::CTRL_MEM2MEM_BIT] & req_ok[0];
      final_xfer = (ccnt_q[ach_q] == 16'h0000);
      // register read mux
      rch = i_s_axi_araddr[6:4];
      rd_map = 1'b1;
      rd_val = 32'h0000_0000;
      if (i_s_axi_araddr[11:7] == dhtc_pkg::OFS_CH_BLOCK)
      begin
         unique case (i_s_axi_araddr[3:2])
            dhtc_pkg::FLD_BASE_ADDR: rd_val = {16'h0000, baddr_q[rch]};
            dhtc_pkg::FLD_BASE_COUNT: rd_val = {16'h0000, bcnt_q[rch]};
            dhtc_pkg::FLD_CUR_ADDR: rd_val = {16'h0000, caddr_q[rch]};
            dhtc_pkg::FLD_CUR_COUNT: rd_val = {16'h0000, ccnt_q[rch]};
         endcase
      end
      else
      begin
         case (i_s_axi_araddr)
            dhtc_pkg::OFS_CTRL: rd_val = ctrl_q;
            dhtc_pkg::OFS_MASK: rd_val = {24'h000000, mask_q};
            dhtc_pkg::OFS_STATUS: rd_val = {12'h000, st_q == dhtc_pkg::DHTC_XFER, ach_q, req, stat_q};
            dhtc_pkg::OFS_IRQ_MASK: rd_val = {24'h000000, imask_q};
            dhtc_pkg::OFS_AUTOINIT: rd_val = {24'h000000, auto_q};
            default: rd_map = 1'b0;
         endcase
      end
      // read channel: take address, answer on the next cycle
      if (rvalid_q && i_s_axi_rready)
      begin
         rvalid_d = 1'b0;
      end
      if (arready_q && i_s_axi_arvalid)
      begin
         rvalid_d = 1'b1;
         rdata_d = rd_map ? rd_val : 32'h0000_0000;
         rresp_d = rd_map ? dhtc_pkg::AXI_OKAY : dhtc_pkg::AXI_SLVERR;
      end
      arready_d = ~rvalid_d;
      // write channel: address and data in either order, then one response
      if (awready_q && i_s_axi_awvalid)
      begin
         have_aw_d = 1'b1;
         awaddr_d = i_s_axi_awaddr;
      end
      if (wready_q && i_s_axi_wvalid)
      begin
         have_w_d = 1'b1;
         wdata_d = i_s_axi_wdata;
         wstrb_d = i_s_axi_wstrb;
      end
      if (bvalid_q && i_s_axi_bready)
      begin
         bvalid_d = 1'b0;
      end
      do_wr = have_aw_q & have_w_q & ~bvalid_q;
      wch = awaddr_q[6:4];
      wr_map = 1'b1;
      if (do_wr)
      begin
         have_aw_d = 1'b0;
         have_w_d = 1'b0;
         bvalid_d = 1'b1;
         if (awaddr_q[11:7] == dhtc_pkg::OFS_CH_BLOCK)
         begin
            unique case (awaddr_q[3:2])
               dhtc_pkg::FLD_BASE_ADDR:
               begin
                  baddr_d[wch] = 16'(merge({16'h0000, baddr_q[wch]}, wdata_q, wstrb_q));
                  caddr_d[wch] = baddr_d[wch];
               end
               dhtc_pkg::FLD_BASE_COUNT:
               begin
                  bcnt_d[wch] = 16'(merge({16'h0000, bcnt_q[wch]}, wdata_q, wstrb_q));
                  ccnt_d[wch] = bcnt_d[wch];
               end
               default: wr_map = 1'b0;
            endcase
         end
         else
         begin
            case (awaddr_q)
               dhtc_pkg::OFS_CTRL: ctrl_d = merge(ctrl_q, wdata_q, wstrb_q);
               dhtc_pkg::OFS_MASK: mask_d = 8'(merge({24'h0, mask_q}, wdata_q, wstrb_q));
               dhtc_pkg::OFS_STATUS: stat_d = stat_q & ~(wdata_q[7:0] & {8{wstrb_q[0]}});
               dhtc_pkg::OFS_IRQ_MASK: imask_d = 8'(merge({24'h0, imask_q}, wdata_q, wstrb_q));
               dhtc_pkg::OFS_AUTOINIT: auto_d = 8'(merge({24'h0, auto_q}, wdata_q, wstrb_q));
               default: wr_map = 1'b0;
            endcase
         end
         bresp_d = wr_map ? dhtc_pkg::AXI_OKAY : dhtc_pkg::AXI_SLVERR;
      end
      awready_d = ~have_aw_d & ~bvalid_d;
      wready_d = ~have_w_d & ~bvalid_d;
      // engine after software writes so that hardware sets win
      unique case (st_q)
         dhtc_pkg::DHTC_IDLE:
         begin
            if (tick && ctrl_q[dhtc_pkg::CTRL_ENABLE_BIT] && found)
            begin
               st_d = dhtc_pkg::DHTC_XFER;
               ph_d = 1'b0;
               m2m_d = m2m_go;
               ach_d = m2m_go ? 3'h1 : pick;
            end
         end
         dhtc_pkg::DHTC_XFER:
         begin
            if (tick && ph_q != dhtc_pkg::XFER_LAST_PHASE)
            begin
               ph_d = dhtc_pkg::XFER_LAST_PHASE;
               tc_d = final_xfer;
            end
            else if (tick)
            begin
               st_d = dhtc_pkg::DHTC_IDLE;
               tc_d = 1'b0;
               ccnt_d[ach_q] = ccnt_q[ach_q] - 16'h0001;
               caddr_d[ach_q] = caddr_q[ach_q] + 16'h0001;
               if (m2m_q)
               begin
                  ccnt_d[0] = ccnt_q[0] - 16'h0001;
                  caddr_d[0] = caddr_q[0] + 16'h0001;
               end
               if (tc_q)
               begin
                  stat_d[ach_q] = 1'b1;
                  if (auto_q[ach_q])
                  begin
                     ccnt_d[ach_q] = bcnt_q[ach_q];
                     caddr_d[ach_q] = baddr_q[ach_q];
                  end
                  else
                  begin
                     mask_d[ach_q] = 1'b1;
                  end
                  if (m2m_q && auto_q[0])
                  begin
                     ccnt_d[0] = bcnt_q[0];
                     caddr_d[0] = baddr_q[0];
                  end
               end
            end
         end
      endcase
      // memory-to-memory runs without peripheral grants
      act = 8'h00;
      if (st_d == dhtc_pkg::DHTC_XFER && !m2m_d)
      begin
         act[ach_d] = 1'b1;
      end
      grant_d = ~(act ^ ctrl_d[dhtc_pkg::CTRL_POL_LSB +: 8]);
      degate_d = (st_d == dhtc_pkg::DHTC_XFER);
      irq_d = |(stat_d & imask_d);
   end

   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         st_q <= dhtc_pkg::DHTC_IDLE;
         ph_q <= 1'b0;
         m2m_q <= 1'b0;
         tc_q <= 1'b0;
         ach_q <= 3'h0;
         ctrl_q <= dhtc_pkg::RST_CTRL;
         mask_q <= dhtc_pkg::RST_MASK;
         stat_q <= 8'h00;
         imask_q <= dhtc_pkg::RST_IRQ_MASK;
         auto_q <= dhtc_pkg::RST_AUTOINIT;
         grant_q <= dhtc_pkg::RST_GRANT;
         degate_q <= 1'b0;
         irq_q <= 1'b0;
         for (int i = 0; i < dhtc_pkg::NUM_CH; i++)
         begin
            baddr_q[i] <= 16'h0000;
            bcnt_q[i] <= 16'h0000;
            caddr_q[i] <= 16'h0000;
            ccnt_q[i] <= 16'h0000;
         end
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         have_aw_q <= 1'b0;
         have_w_q <= 1'b0;
         awaddr_q <= 12'h000;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'h0;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= 2'h0;
      end
      else
      begin
         st_q <= st_d;
         ph_q <= ph_d;
         m2m_q <= m2m_d;
         tc_q <= tc_d;
         ach_q <= ach_d;
         ctrl_q <= ctrl_d;
         mask_q <= mask_d;
         stat_q <= stat_d;
         imask_q <= imask_d;
         auto_q <= auto_d;
         grant_q <= grant_d;
         degate_q <= degate_d;
         irq_q <= irq_d;
         baddr_q <= baddr_d;
         bcnt_q <= bcnt_d;
         caddr_q <= caddr_d;
         ccnt_q <= ccnt_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         have_aw_q <= have_aw_d;
         have_w_q <= have_w_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   assign o_s_axi_awready = awready_q;
   assign o_s_axi_wready = wready_q;
   assign o_s_axi_bvalid = bvalid_q;
   assign o_s_axi_bresp = bresp_q;
   assign o_s_axi_arready = arready_q;
   assign o_s_axi_rvalid = rvalid_q;
   assign o_s_axi_rdata = rdata_q;
   assign o_s_axi_rresp = rresp_q;
   assign o_dma_grant_low_channels = grant_q[3:0];
   assign o_dma_grant_high_channels = grant_q[7:5];
   assign o_count_done_pulse = tc_q;
   assign o_io_channel_degate = degate_q;
   assign o_irq = irq_q;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);

   AST_GRANT_ONE: assert property ($onehot0(~(grant_q ^ ctrl_q[15:8])))
      else $error("more than one grant active");
   AST_GRANT_LEVEL: assert property ($rose(st_q == dhtc_pkg::DHTC_XFER) && !m2m_q
      |-> grant_q[ach_q] == ctrl_q[dhtc_pkg::CTRL_POL_LSB + ach_q])
      else $error("grant of active channel not at its programmed level");
   AST_TC_WIDTH: assert property (tc_q && !tick |=> tc_q)
      else $error("completion pulse dropped between dma clocks");
   AST_TC_FALL: assert property (tc_q && tick |=> !tc_q && st_q == dhtc_pkg::DHTC_IDLE)
      else $error("service not ended with the completion pulse");
   // the rise checks the count that made this transfer final
   AST_TC_M2M: assert property (tc_q && m2m_q
      |-> ach_q == 3'h1 && (!$rose(tc_q) || $past(ccnt_q[1]) == 16'h0000))
      else $error("memory-to-memory pulse not from channel 1 terminal count");
   AST_AUTOINIT: assert property (tc_q && tick && auto_q[ach_q] && !mask_q[ach_q]
      && !do_wr |=> ccnt_q[ach_q] == $past(bcnt_q[ach_q])
      && caddr_q[ach_q] == $past(baddr_q[ach_q]) && !mask_q[ach_q])
      else $error("auto-init reload missing or mask set");
   AST_TC_MASK: assert property (tc_q && tick && !auto_q[ach_q] |=> mask_q[ach_q] && stat_q[ach_q])
      else $error("mask or status bit not set at terminal count");
   AST_NO_REQ_CACHE: assert property (st_q == dhtc_pkg::DHTC_IDLE
      && !ctrl_q[dhtc_pkg::CTRL_NONCACHE_BIT] |=> st_q == dhtc_pkg::DHTC_IDLE)
      else $error("transfer started in cache configuration");
   AST_DEGATE: assert property ($rose(st_q == dhtc_pkg::DHTC_XFER) |-> o_io_channel_degate)
      else $error("degate not raised with transfer");
   COV_TC: cover property (tc_q && tick && !m2m_q);
   COV_TC_M2M: cover property (tc_q && tick && m2m_q);
   COV_AUTO: cover property (tc_q && tick && auto_q[ach_q]);
endmodule
`default_nettype wire

// *** dhtc_periph_model.sv ***
// Purpose: peripherals on the far side that raise dma requests on the shared pins
// Assumes: grants are kept active low by software, channel 4 never requests
// Notes: a request drops once its grant is seen and comes back only after the grant ends
`timescale 1ns/1ps
`default_nettype none
module dhtc_periph_model (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_arst_n,
   // bench control, one bit per channel
   input wire logic [7:0] i_want,
   // grants from the device
   input wire logic [3:0] i_dma_grant_low_channels,
   input wire logic [2:0] i_dma_grant_high_channels,
   // requests to the device
   output logic [3:0] o_cache_byte_select_n,
   output logic [2:0] o_tag_data_low_bits
);
   logic [7:0] req_q;
   logic [7:0] req_d;
   logic [7:0] grant_seen;

   always_comb
   begin
      grant_seen = ~{i_dma_grant_high_channels, 1'b1, i_dma_grant_low_channels};
      req_d = i_want & ~grant_seen;
   end

   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
         req_q <= 8'h00;
      else
         req_q <= req_d;
   end

   assign o_cache_byte_select_n = req_q[3:0];
   assign o_tag_data_low_bits = req_q[7:5];
endmodule
`default_nettype wire

// *** dhtc_top_tb.sv ***
// Purpose: self-checking bench for the dma grant and terminal-count unit
// Assumes: registers reached over axi4-lite, peripherals modelled on the far side
// Notes: reference runs free near 14.318 MHz, unrelated in phase to i_clock
`timescale 1ns/1ps
`default_nettype none
module dhtc_top_tb;
   logic i_clock = 1'b0;
   logic i_arst_n = 1'b0;
   logic refclk = 1'b0;
   logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic [11:0] awa = 12'h000, ara = 12'h000;
   logic [31:0] wd = 32'h0000_0000;
   logic awr, wr_rdy, bv, arr, rv, irq, done_p, degate, deg;
   logic [1:0] br, rr, resp;
   logic [31:0] rd;
   logic [3:0] gl, csel;
   logic [2:0] gh, tag;
   logic [7:0] want = 8'h00;
   logic [7:0] gall, g;
   int errors = 0, check_count = 0, n, w;

   assign gall = {gh, 1'b1, gl};
   always #4 i_clock = ~i_clock;
   always #34.92 refclk = ~refclk;

   dhtc_top u_dut (
      .i_clock(i_clock), .i_arst_n(i_arst_n),
      .i_s_axi_awvalid(awv), .i_s_axi_awaddr(awa), .o_s_axi_awready(awr),
      .i_s_axi_wvalid(wv), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .o_s_axi_wready(wr_rdy),
      .o_s_axi_bvalid(bv), .o_s_axi_bresp(br), .i_s_axi_bready(bre),
      .i_s_axi_arvalid(arv), .i_s_axi_araddr(ara), .o_s_axi_arready(arr),
      .o_s_axi_rvalid(rv), .o_s_axi_rdata(rd), .o_s_axi_rresp(rr), .i_s_axi_rready(rre),
      .i_reference_clock_in(refclk), .i_tag_data_low_bits(tag), .i_cache_byte_select_n(csel),
      .o_dma_grant_low_channels(gl), .o_dma_grant_high_channels(gh),
      .o_count_done_pulse(done_p), .o_io_channel_degate(degate), .o_irq(irq)
   );

   dhtc_periph_model u_periph (
      .i_clock(i_clock), .i_arst_n(i_arst_n), .i_want(want),
      .i_dma_grant_low_channels(gl), .i_dma_grant_high_channels(gh),
      .o_cache_byte_select_n(csel), .o_tag_data_low_bits(tag)
   );

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // address and data offered together, each released once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge i_clock);
      awv <= 1'b1;
      awa <= a;
      wv <= 1'b1;
      wd <= d;
      bre <= 1'b1;
      do
      begin
         @(posedge i_clock);
         if (awv && awr)
            awv <= 1'b0;
         if (wv && wr_rdy)
            wv <= 1'b0;
         if (bre && bv)
         begin
            bre <= 1'b0;
            r = br;
         end
      end while (bre);
   endtask

   task automatic rdr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge i_clock);
      arv <= 1'b1;
      ara <= a;
      rre <= 1'b1;
      do
      begin
         @(posedge i_clock);
         if (arv && arr)
            arv <= 1'b0;
         if (rre && rv)
         begin
            rre <= 1'b0;
            d = rd;
            r = rr;
         end
      end while (rre);
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rdr(a, d, r);
      chk(d & m, exp);
   endtask

   task automatic wait_grant(input int ch);
      for (n = 0; n < 400 && gall[ch] !== 1'b0; n++)
         @(posedge i_clock);
   endtask

   // width in clocks; grant and degate are taken where the pulse first shows
   task automatic pulse_width(output int wid, output logic dg, output logic [7:0] gs);
      wid = 0;
      for (n = 0; n < 600 && done_p !== 1'b1; n++)
         @(posedge i_clock);
      dg = degate;
      gs = gall;
      while (done_p === 1'b1 && wid < 100)
      begin
         @(posedge i_clock);
         wid++;
      end
   endtask

   task automatic finish_test;
      $display("Checks %0d, errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // whole run is a few hundred clocks
   initial
   begin
      repeat (40000) @(posedge i_clock);
      errors++;
      finish_test();
   end

   initial
   begin
      logic [31:0] v;
      repeat (12) @(posedge i_clock);
      chk({24'h0, gall}, 32'hff);
      chk({29'h0, done_p, degate, irq}, 32'h0);
      i_arst_n <= 1'b1;
      rchk(12'h000, 32'hffff_ffff, 32'h0);
      rchk(12'h004, 32'hffff_ffff, 32'hff);
      rchk(12'h00c, 32'hffff_ffff, 32'h0);
      rchk(12'h010, 32'hffff_ffff, 32'h0);
      rdr(12'h300, v, resp);
      chk(v, 32'h0);
      chk({30'h0, resp}, {30'h0, dhtc_pkg::AXI_SLVERR});
      wr(12'h0ac, 32'h5, resp);
      chk({30'h0, resp}, {30'h0, dhtc_pkg::AXI_SLVERR});
      // channel 2: two transfers, the second one final
      wr(12'h0a0, 32'h1000, resp);
      wr(12'h0a4, 32'h1, resp);
      wr(12'h004, 32'hfb, resp);
      wr(12'h00c, 32'h04, resp);
      wr(12'h000, 32'h1, resp);
      want <= 8'h04;
      repeat (60) @(posedge i_clock);
      chk({24'h0, gall}, 32'hff);
      wr(12'h000, 32'h3, resp);
      wait_grant(2);
      chk({31'h0, gall[2]}, 32'h0);
      chk({31'h0, degate}, 32'h1);
      pulse_width(w, deg, g);
      want <= 8'h00;
      chk({31'h0, w >= 8 && w <= 9}, 32'h1);
      chk({23'h0, deg, g}, 32'h1fb);
      chk({23'h0, degate, gall}, 32'h0ff);
      rchk(12'h008, 32'hff, 32'h04);
      rchk(12'h004, 32'hff, 32'hff);
      rchk(12'h0ac, 32'hffff, 32'hffff);
      rchk(12'h0a8, 32'hffff, 32'h1002);
      chk({31'h0, irq}, 32'h1);
      wr(12'h008, 32'h04, resp);
      chk({31'h0, irq}, 32'h0);
      // channel 6 on the tag pins, auto-initialising, interrupt masked
      wr(12'h0e0, 32'h2000, resp);
      wr(12'h0e4, 32'h0, resp);
      wr(12'h010, 32'h40, resp);
      wr(12'h004, 32'hbf, resp);
      want <= 8'h40;
      wait_grant(6);
      chk({24'h0, gall}, 32'hbf);
      pulse_width(w, deg, g);
      // channel stays unmasked under auto-init, so stop asking before it rearms
      want <= 8'h00;
      chk({31'h0, w >= 8 && w <= 9}, 32'h1);
      rchk(12'h004, 32'hff, 32'hbf);
      rchk(12'h0ec, 32'hffff, 32'h0);
      rchk(12'h0e8, 32'hffff, 32'h2000);
      rchk(12'h008, 32'hff, 32'h40);
      chk({31'h0, irq}, 32'h0);
      wr(12'h004, 32'hff, resp);
      wr(12'h010, 32'h0, resp);
      wr(12'h008, 32'h40, resp);
      // grant level follows its polarity bit
      wr(12'h000, 32'h0803, resp);
      chk({24'h0, gall}, 32'hf7);
      wr(12'h000, 32'h3, resp);
      chk({24'h0, gall}, 32'hff);
      // memory copy: channel 0 ends first without a pulse, the pulse waits for channel 1
      wr(12'h084, 32'h0, resp);
      wr(12'h094, 32'h1, resp);
      wr(12'h004, 32'hfc, resp);
      wr(12'h000, 32'h7, resp);
      want <= 8'h01;
      pulse_width(w, deg, g);
      want <= 8'h00;
      chk({31'h0, deg}, 32'h1);
      chk({31'h0, w >= 8 && w <= 9}, 32'h1);
      rchk(12'h008, 32'h3, 32'h2);
      rchk(12'h08c, 32'hffff, 32'hfffe);
      rchk(12'h09c, 32'hffff, 32'hffff);
      rchk(12'h004, 32'h3, 32'h2);
      finish_test();
   end
endmodule
`default_nettype wire
